// ===== include/led_dim_pkg.sv
// constants shared by the backlight dimming and protection controller
// assumes a single 40 MHz clock and comparator flags arriving asynchronously from analog
package led_dim_pkg;

    // --------------------------------------------------------------------
    // clock and boost timing
    // --------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SW_FREQ_HZ = 600_000;
    // nearest whole cycle count to the nominal switching rate
    localparam int unsigned SW_PERIOD = (CLK_HZ + SW_FREQ_HZ / 2) / SW_FREQ_HZ;
    localparam int unsigned SW_W = 7;
    localparam int unsigned MIN_ON_NS = 100;
    localparam int unsigned MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [SW_W-1:0] SW_LAST = SW_W'(SW_PERIOD - 1);
    localparam logic [SW_W-1:0] MIN_ON_LAST = SW_W'(MIN_ON_CYC - 1);

    // --------------------------------------------------------------------
    // dimming
    // --------------------------------------------------------------------
    localparam int unsigned DUTY_W = 10;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h3ff;
    localparam logic [DUTY_W-1:0] DUTY_TRANSFER = 10'h100;
    // 0.2 % of full scale is about two codes
    localparam logic [DUTY_W-1:0] DUTY_HYST = 10'h002;
    localparam logic [DUTY_W-1:0] DUTY_QUARTER = 10'h100;
    localparam int unsigned MEAS_W = 20;
    localparam logic [MEAS_W-1:0] MEAS_MAX = 20'hfffff;
    localparam int unsigned QUO_W = DUTY_W + 1;
    localparam logic [3:0] QUO_TOP = 4'ha;
    localparam int unsigned DIM_OUT_HZ = 26_500;
    localparam int unsigned DIM_PERIOD = CLK_HZ / DIM_OUT_HZ;
    localparam int unsigned DIM_W = 11;
    localparam logic [DIM_W-1:0] DIM_LAST = DIM_W'(DIM_PERIOD - 1);

    // --------------------------------------------------------------------
    // protection and start-up
    // --------------------------------------------------------------------
    localparam int unsigned STRINGS = 6;
    localparam int unsigned FAULT_TIME_US = 3200;
    localparam int unsigned FAULT_TICKS = FAULT_TIME_US * (SW_FREQ_HZ / 1000) / 1000;
    localparam int unsigned FAULT_W = 12;
    localparam int unsigned SS_W = 8;
    localparam logic [SS_W-1:0] SS_MAX = 8'hff;
    localparam int unsigned SS_STEP_TICKS = 4;
    localparam int unsigned SS_DIV_W = 8;
    localparam int unsigned N_ASYNC = 9 + 2 * STRINGS;

    typedef enum logic [5:0] {
        ST_OFF     = 6'h01,
        ST_CHECK   = 6'h02,
        ST_SOFT    = 6'h04,
        ST_RUN     = 6'h08,
        ST_OVP     = 6'h10,
        ST_THERMAL = 6'h20
    } ctrl_state_e;

endpackage : led_dim_pkg

// ===== design/led_backlight_dim_protect_ctrl.sv
// backlight boost controller: dimming mode select, dim regeneration, start-up, boost timing, faults
// assumes all flag inputs are asynchronous comparator or pin levels; analog loop lives outside
`timescale 1ns/10ps

// Function
// - duty at or above quarter: analog dimming, amplitude equals full scale times duty
// - duty below quarter: amplitude a quarter, string duty four times input duty
// - low-duty string waveform regenerated between 23.5 and 29.5 kHz
// - after enable, no switching while output sense below short threshold
// - start only when lockout and over-temperature clear, through soft-start
// - whole block held off while internal supply below lockout threshold
// - enable and dimming inputs read low when undriven
// - fixed 600 kHz boost period, switch turned on each cycle start except skipped cycles at light load
// - switch on-time never below minimum on-time; code cuts a pulse short as soon as switching_active falls
// - switch off once peak-current comparator trips
// - light load: one minimum pulse, then off until boost needed again
// - feedback uses only active strings, marked-off strings excluded
// - six independent sinks each switched by the dimming logic
// - string over-voltage timer nominally 3.2 ms counted in switching cycles
// - persisting string over-voltage disables string; restored once condition clears
// - output over-voltage stops switching until sense falls below recovery
// - at output over-voltage mark off low strings; restore on reconnect
// - over-temperature shuts down, resumes automatically once clear
module led_backlight_dim_protect_ctrl #(
    parameter int unsigned FAULT_TICKS = led_dim_pkg::FAULT_TICKS,
    parameter int unsigned SS_STEP_TICKS = led_dim_pkg::SS_STEP_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host pins
    input wire logic enable_pin,
    input wire logic dim_pin,
    // supply and thermal flags
    input wire logic supply_ok,
    input wire logic over_temp,
    // output voltage sense comparators
    input wire logic output_above_short,
    input wire logic output_overvoltage_sense,
    input wire logic output_recovered,
    // boost loop comparators
    input wire logic peak_current_trip,
    input wire logic light_load,
    // string sink pin comparators
    input wire logic [led_dim_pkg::STRINGS-1:0] string_high,
    input wire logic [led_dim_pkg::STRINGS-1:0] string_low,
    // boost switch
    output logic power_switch_on,
    // string sinks and feedback selection
    output logic [led_dim_pkg::STRINGS-1:0] string_sink_on,
    output logic [led_dim_pkg::STRINGS-1:0] feedback_select,
    output logic [led_dim_pkg::DUTY_W-1:0] current_amplitude,
    // status
    output logic analog_dimming,
    output logic [led_dim_pkg::SS_W-1:0] softstart_ref,
    output logic switching_active,
    output logic [led_dim_pkg::STRINGS-1:0] string_shorted,
    output logic [led_dim_pkg::STRINGS-1:0] string_marked_off
);

    // --------------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------------
    localparam int unsigned NA = led_dim_pkg::N_ASYNC;
    logic [NA-1:0] raw_in;
    logic [NA-1:0] sync1;
    logic [NA-1:0] sync2;
    logic [NA-1:0] sync3;
    logic [NA-1:0] filt;

    assign raw_in = {string_low, string_high, light_load, peak_current_trip, output_recovered,
                     output_overvoltage_sense, output_above_short, over_temp, supply_ok, dim_pin, enable_pin};

    always_ff @(posedge clk) begin
        sync1 <= raw_in;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // cleared filter reads both host pins as low until a driven level gets through
    always_ff @(posedge clk) begin
        if (reset) begin
            filt <= '0;
        end else begin
            filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
        end
    end

    logic en_s, dim_s, supply_s, hot_s, above_short_s, ovp_s, recovered_s, peak_s, light_s;
    logic [led_dim_pkg::STRINGS-1:0] str_high_s, str_low_s;
    assign {str_low_s, str_high_s, light_s, peak_s, recovered_s, ovp_s, above_short_s, hot_s, supply_s, dim_s, en_s} =
        filt;

    // --------------------------------------------------------------------
    // input duty measurement
    // --------------------------------------------------------------------
    logic dim_prev;
    logic period_seen;
    logic [led_dim_pkg::MEAS_W-1:0] per_cnt;
    logic [led_dim_pkg::MEAS_W-1:0] high_cnt;
    logic [led_dim_pkg::MEAS_W-1:0] lat_high;
    logic [led_dim_pkg::MEAS_W-1:0] lat_per;
    logic meas_go;
    logic dim_rise;
    logic stale;
    localparam logic [led_dim_pkg::MEAS_W-1:0] MEAS_ONE = 20'h00001;

    assign dim_rise = dim_s & ~dim_prev;
    // a static input never produces an edge, so a saturated period reports its level
    assign stale = (per_cnt == led_dim_pkg::MEAS_MAX);

    always_ff @(posedge clk) begin
        if (reset) begin
            dim_prev <= 1'b0;
            period_seen <= 1'b0;
            per_cnt <= '0;
            high_cnt <= '0;
            lat_high <= '0;
            lat_per <= '0;
            meas_go <= 1'b0;
        end else begin
            dim_prev <= dim_s;
            meas_go <= 1'b0;
            if (dim_rise || stale) begin
                period_seen <= 1'b1;
                meas_go <= period_seen || stale;
                lat_high <= dim_rise ? high_cnt : (dim_s ? led_dim_pkg::MEAS_MAX : '0);
                lat_per <= dim_rise ? per_cnt : led_dim_pkg::MEAS_MAX;
                per_cnt <= MEAS_ONE;
                high_cnt <= dim_s ? MEAS_ONE : '0;
            end else begin
                per_cnt <= per_cnt + MEAS_ONE;
                high_cnt <= high_cnt + (dim_s ? MEAS_ONE : '0);
            end
        end
    end

    // restoring divider: duty = high * 1024 / period, one quotient bit per clock
    localparam int unsigned REM_W = led_dim_pkg::MEAS_W + led_dim_pkg::DUTY_W + 1;
    logic div_busy;
    logic div_done;
    logic [3:0] div_bit;
    logic [REM_W-1:0] div_rem;
    logic [led_dim_pkg::MEAS_W-1:0] div_den;
    logic [led_dim_pkg::QUO_W-1:0] div_q;
    logic [REM_W-1:0] den_shift;
    assign den_shift = REM_W'(div_den) << div_bit;

    always_ff @(posedge clk) begin
        if (reset) begin
            div_busy <= 1'b0;
            div_done <= 1'b0;
            div_bit <= '0;
            div_rem <= '0;
            div_den <= '0;
            div_q <= '0;
        end else begin
            div_done <= 1'b0;
            if (meas_go && !div_busy) begin
                div_busy <= 1'b1;
                div_bit <= led_dim_pkg::QUO_TOP;
                div_rem <= {1'b0, lat_high, {led_dim_pkg::DUTY_W{1'b0}}};
                div_den <= lat_per;
                div_q <= '0;
            end else if (div_busy) begin
                if (div_rem >= den_shift) begin
                    div_rem <= div_rem - den_shift;
                    div_q[div_bit] <= 1'b1;
                end
                div_bit <= div_bit - 4'h1;
                if (div_bit == 4'h0) begin
                    div_busy <= 1'b0;
                    div_done <= 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------------
    // dimming mode, amplitude and regenerated string waveform
    // --------------------------------------------------------------------
    logic [led_dim_pkg::DUTY_W-1:0] duty;
    logic [led_dim_pkg::DUTY_W-1:0] next_duty;
    logic [led_dim_pkg::DIM_W-1:0] dim_cnt;
    logic [led_dim_pkg::DIM_W-1:0] dim_on_cycles;
    logic dim_wave;
    localparam int unsigned DIM_ON_W = led_dim_pkg::DIM_W;
    localparam logic [led_dim_pkg::DIM_W-1:0] DIM_ONE = 11'h001;

    assign next_duty = div_q[led_dim_pkg::DUTY_W] ? led_dim_pkg::DUTY_MAX : div_q[led_dim_pkg::DUTY_W-1:0];

    always_ff @(posedge clk) begin
        if (reset) begin
            duty <= '0;
            analog_dimming <= 1'b0;
            dim_on_cycles <= '0;
        end else if (div_done) begin
            duty <= next_duty;
            if (next_duty >= led_dim_pkg::DUTY_TRANSFER) begin
                analog_dimming <= 1'b1;
            end else if (next_duty < led_dim_pkg::DUTY_TRANSFER - led_dim_pkg::DUTY_HYST) begin
                analog_dimming <= 1'b0;
            end
            // on-time of four times the input duty within one output period
            dim_on_cycles <= DIM_ON_W'((32'(next_duty) * 32'(4 * led_dim_pkg::DIM_PERIOD)) >> led_dim_pkg::DUTY_W);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dim_cnt <= '0;
        end else if (dim_cnt == led_dim_pkg::DIM_LAST) begin
            dim_cnt <= '0;
        end else begin
            dim_cnt <= dim_cnt + DIM_ONE;
        end
    end

    assign dim_wave = analog_dimming | (dim_cnt < dim_on_cycles);

    always_ff @(posedge clk) begin
        if (reset) begin
            current_amplitude <= '0;
        end else begin
            current_amplitude <= analog_dimming ? duty : led_dim_pkg::DUTY_QUARTER;
        end
    end

    // --------------------------------------------------------------------
    // start-up and protection sequencer
    // --------------------------------------------------------------------
    led_dim_pkg::ctrl_state_e state;
    led_dim_pkg::ctrl_state_e next_state;
    logic chip_on;
    logic ss_done;
    logic sw_tick;
    assign chip_on = en_s & supply_s;

    always_comb begin
        next_state = state;
        case (state)
            led_dim_pkg::ST_OFF: begin
                next_state = led_dim_pkg::ST_CHECK;
            end
            led_dim_pkg::ST_CHECK: begin
                if (hot_s) begin
                    next_state = led_dim_pkg::ST_THERMAL;
                end else if (above_short_s && supply_s) begin
                    next_state = led_dim_pkg::ST_SOFT;
                end
            end
            led_dim_pkg::ST_SOFT, led_dim_pkg::ST_RUN: begin
                if (hot_s) begin
                    next_state = led_dim_pkg::ST_THERMAL;
                end else if (ovp_s) begin
                    next_state = led_dim_pkg::ST_OVP;
                end else if (state == led_dim_pkg::ST_SOFT && ss_done) begin
                    next_state = led_dim_pkg::ST_RUN;
                end
            end
            led_dim_pkg::ST_OVP: begin
                if (hot_s) begin
                    next_state = led_dim_pkg::ST_THERMAL;
                end else if (recovered_s && !ovp_s) begin
                    next_state = led_dim_pkg::ST_RUN;
                end
            end
            led_dim_pkg::ST_THERMAL: begin
                if (!hot_s) begin
                    next_state = led_dim_pkg::ST_CHECK;
                end
            end
            default: begin
                next_state = led_dim_pkg::ST_OFF;
            end
        endcase
        if (!chip_on) begin
            next_state = led_dim_pkg::ST_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= led_dim_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // soft-start ramp, one step every few switching cycles
    localparam int unsigned SS_DIV_W = led_dim_pkg::SS_DIV_W;
    localparam logic [led_dim_pkg::SS_W-1:0] SS_ONE = 8'h01;
    localparam logic [SS_DIV_W-1:0] SS_DIV_ONE = 8'h01;
    logic [led_dim_pkg::SS_DIV_W-1:0] ss_div;
    assign ss_done = (softstart_ref == led_dim_pkg::SS_MAX);

    always_ff @(posedge clk) begin
        if (reset || state == led_dim_pkg::ST_OFF || state == led_dim_pkg::ST_CHECK
                || state == led_dim_pkg::ST_THERMAL) begin
            softstart_ref <= '0;
            ss_div <= '0;
        end else if (state == led_dim_pkg::ST_SOFT && sw_tick && !ss_done) begin
            if (ss_div == SS_DIV_W'(SS_STEP_TICKS - 1)) begin
                ss_div <= '0;
                softstart_ref <= softstart_ref + SS_ONE;
            end else begin
                ss_div <= ss_div + SS_DIV_ONE;
            end
        end
    end

    // --------------------------------------------------------------------
    // boost switch timing
    // --------------------------------------------------------------------
    logic [led_dim_pkg::SW_W-1:0] sw_cnt;
    logic [led_dim_pkg::SW_W-1:0] on_cnt;
    logic skipping;
    logic min_pulse;
    localparam logic [led_dim_pkg::SW_W-1:0] SW_ONE = 7'h01;

    assign sw_tick = (sw_cnt == led_dim_pkg::SW_LAST);
    assign switching_active = (state == led_dim_pkg::ST_SOFT) || (state == led_dim_pkg::ST_RUN);

    always_ff @(posedge clk) begin
        if (reset || sw_tick) begin
            sw_cnt <= '0;
        end else begin
            sw_cnt <= sw_cnt + SW_ONE;
        end
    end

    // comparator flags pass the synchroniser and filter, so turn-off lags the trip by about five clocks
    always_ff @(posedge clk) begin
        if (reset || !switching_active) begin
            power_switch_on <= 1'b0;
            on_cnt <= '0;
            skipping <= 1'b0;
            min_pulse <= 1'b0;
        end else if (sw_tick) begin
            on_cnt <= '0;
            min_pulse <= light_s;
            skipping <= light_s;
            power_switch_on <= !(light_s && skipping);
        end else if (power_switch_on) begin
            on_cnt <= on_cnt + SW_ONE;
            if (on_cnt >= led_dim_pkg::MIN_ON_LAST && (min_pulse || peak_s)) begin
                power_switch_on <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------
    // per-string fault handling and sinks
    // --------------------------------------------------------------------
    logic ovp_entry;
    logic sinks_enabled;
    localparam int unsigned FAULT_W = led_dim_pkg::FAULT_W;
    localparam logic [led_dim_pkg::FAULT_W-1:0] FAULT_ONE = 12'h001;
    assign ovp_entry = switching_active && next_state == led_dim_pkg::ST_OVP;
    assign sinks_enabled = switching_active || state == led_dim_pkg::ST_OVP;

    genvar gi;
    generate
        for (gi = 0; gi < led_dim_pkg::STRINGS; gi++) begin : g_string
            logic [led_dim_pkg::FAULT_W-1:0] short_cnt;
            logic active;
            assign active = !string_shorted[gi] && !string_marked_off[gi];

            always_ff @(posedge clk) begin
                if (reset || state == led_dim_pkg::ST_OFF || !str_high_s[gi]) begin
                    short_cnt <= '0;
                    string_shorted[gi] <= 1'b0;
                end else if (short_cnt == FAULT_W'(FAULT_TICKS)) begin
                    string_shorted[gi] <= 1'b1;
                end else if (sw_tick) begin
                    short_cnt <= short_cnt + FAULT_ONE;
                end
            end

            // marking wins over the reconnect clear in the same cycle
            always_ff @(posedge clk) begin
                if (reset || state == led_dim_pkg::ST_OFF) begin
                    string_marked_off[gi] <= 1'b0;
                end else if (ovp_entry && str_low_s[gi]) begin
                    string_marked_off[gi] <= 1'b1;
                end else if (!str_low_s[gi]) begin
                    string_marked_off[gi] <= 1'b0;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    string_sink_on[gi] <= 1'b0;
                    feedback_select[gi] <= 1'b0;
                end else begin
                    string_sink_on[gi] <= active && dim_wave && sinks_enabled;
                    feedback_select[gi] <= active && sinks_enabled;
                end
            end
        end
    endgenerate

endmodule : led_backlight_dim_protect_ctrl

// ===== bench/led_host_model.sv
// host side model: enable driver and pwm dimming source
// assumes the bench gives period and high time in clock cycles
`timescale 1ns/10ps
module led_host_model (
    // clock and requests
    input wire logic clk,
    input wire logic en_req,
    input wire logic [19:0] period,
    input wire logic [19:0] high,
    // pins
    output logic enable_pin,
    output logic dim_pin
);
    logic [19:0] cnt = 20'h0;
    logic settled = 1'b0;
    initial enable_pin = 1'b0;
    initial dim_pin = 1'b0;
    // enable waits for the start of the next dimming period, so no inrush on a half-formed dim level
    always @(posedge clk) begin
        cnt <= (cnt + 20'h1 >= period) ? 20'h0 : cnt + 20'h1;
        dim_pin <= cnt < high;
        if (cnt == 20'h0) settled <= en_req;
        enable_pin <= en_req && settled;
    end
endmodule : led_host_model

// ===== bench/led_backlight_dim_protect_ctrl_chk.sv
// checker for the backlight controller ports
// assumes it is bound to the controller and sees its ports only
`timescale 1ns/10ps
module led_backlight_dim_protect_ctrl_chk #(
    parameter int unsigned FAULT_TICKS = led_dim_pkg::FAULT_TICKS,
    parameter int unsigned SS_STEP_TICKS = led_dim_pkg::SS_STEP_TICKS
) (
    // clock, reset and flags
    input wire logic clk,
    input wire logic reset,
    input wire logic output_overvoltage_sense,
    input wire logic peak_current_trip,
    input wire logic light_load,
    // outputs watched
    input wire logic power_switch_on,
    input wire logic [5:0] string_sink_on,
    input wire logic [5:0] feedback_select,
    input wire logic [9:0] current_amplitude,
    input wire logic analog_dimming,
    input wire logic [7:0] softstart_ref,
    input wire logic switching_active,
    input wire logic [5:0] string_shorted,
    input wire logic [5:0] string_marked_off
);
    // ----------------------------------------------------------------
    // helpers: gap 0 means no pulse seen since reset, ff means too long
    // ----------------------------------------------------------------
    logic prev_on;
    logic [7:0] gap;
    logic [7:0] ll_cnt;
    logic gap_valid;
    logic [5:0] off_all;
    assign gap_valid = gap != 8'h0 && gap != 8'hff;
    assign off_all = string_marked_off | string_shorted;
    always_ff @(posedge clk) prev_on <= power_switch_on;
    always_ff @(posedge clk) begin
        if (reset) gap <= 8'h0;
        else if (power_switch_on && !prev_on) gap <= 8'h1;
        else if (gap_valid) gap <= gap + 8'h1;
    end
    always_ff @(posedge clk) begin
        if (reset || !light_load) ll_cnt <= 8'h0;
        else if (ll_cnt != 8'hff) ll_cnt <= ll_cnt + 8'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_min_on_time: assert property ($rose(power_switch_on) |-> (power_switch_on || !switching_active) [*4])
        else $error("pulse too short");
    chk_switch_period: assert property ($rose(power_switch_on) && gap_valid |-> gap % led_dim_pkg::SW_PERIOD == 0)
        else $error("switch period off");
    chk_peak_off: assert property ($rose(peak_current_trip) && power_switch_on |-> ##[1:8] !power_switch_on)
        else $error("peak trip ignored");
    chk_skip_hold: assert property (ll_cnt >= 8'h8c |-> !$rose(power_switch_on))
        else $error("pulse during skip");
    chk_ovp_stop: assert property (output_overvoltage_sense [*7] |-> !switching_active)
        else $error("switching in overvoltage");
    chk_sink_active: assert property ((string_sink_on & ~feedback_select) == 6'h0)
        else $error("sink on for inactive string");
    chk_fault_exclude: assert property ((off_all & $past(off_all) & $past(off_all, 2) & feedback_select) == 6'h0)
        else $error("faulted string in feedback");
    chk_pwm_amp: assert property (!analog_dimming [*2] |-> current_amplitude == led_dim_pkg::DUTY_QUARTER)
        else $error("pwm amplitude wrong");
    chk_analog_amp: assert property (analog_dimming [*2] |-> current_amplitude >= 10'h0fe)
        else $error("analog amplitude low");
    chk_soft_step: assert property (switching_active && $past(switching_active) && $changed(softstart_ref)
        |-> softstart_ref == $past(softstart_ref) + 8'h1) else $error("soft-start jumped");
    cov_soft_done: cover property (softstart_ref == 8'hff);
    cov_shorted: cover property (string_shorted != 6'h0);
    cov_marked: cover property (string_marked_off != 6'h0);
endmodule : led_backlight_dim_protect_ctrl_chk

bind led_backlight_dim_protect_ctrl led_backlight_dim_protect_ctrl_chk #(
    .FAULT_TICKS(FAULT_TICKS), .SS_STEP_TICKS(SS_STEP_TICKS)) u_chk (
    .clk(clk), .reset(reset), .output_overvoltage_sense(output_overvoltage_sense),
    .peak_current_trip(peak_current_trip), .light_load(light_load), .power_switch_on(power_switch_on),
    .string_sink_on(string_sink_on), .feedback_select(feedback_select), .current_amplitude(current_amplitude),
    .analog_dimming(analog_dimming), .softstart_ref(softstart_ref), .switching_active(switching_active),
    .string_shorted(string_shorted), .string_marked_off(string_marked_off));

// ===== bench/test_led_backlight_dim_protect_ctrl.sv
// self-checking bench for the backlight controller
// assumes the host model drives enable and dim, the checker is bound in
`timescale 1ns/10ps
module test_led_backlight_dim_protect_ctrl;
    // ----------------------------------------------------------------
    // stimulus, observation and shared tasks
    // ----------------------------------------------------------------
    logic clk = 1'b0, reset = 1'b1, en_req = 1'b0, supply_ok = 1'b1, over_temp = 1'b0;
    logic above_short = 1'b0, ovs = 1'b0, recov = 1'b1, peak = 1'b1, light = 1'b0;
    logic [5:0] s_high = 6'h0, s_low = 6'h0;
    logic enable_pin, dim_pin, sw, active, analog;
    logic [5:0] sink, fb, shorted, marked;
    logic [9:0] amp;
    logic [7:0] ssref;
    int failures = 0, n_compared = 0, c_sink, r_sink, c_sw, r_sw, d, exp_a = 0;
    int period = 3000, high = 300;
    int pt[3] = '{2000, 2048, 2048};
    int ht[3] = '{500, 508, 506};
    always #12.5 clk = ~clk;
    led_host_model u_host (.clk(clk), .en_req(en_req), .period(20'(period)), .high(20'(high)),
        .enable_pin(enable_pin), .dim_pin(dim_pin));
    led_backlight_dim_protect_ctrl #(.FAULT_TICKS(8), .SS_STEP_TICKS(1)) u_dut (
        .clk(clk), .reset(reset), .enable_pin(enable_pin), .dim_pin(dim_pin), .supply_ok(supply_ok),
        .over_temp(over_temp), .output_above_short(above_short), .output_overvoltage_sense(ovs),
        .output_recovered(recov), .peak_current_trip(peak), .light_load(light), .string_high(s_high),
        .string_low(s_low), .power_switch_on(sw), .string_sink_on(sink), .feedback_select(fb),
        .current_amplitude(amp), .analog_dimming(analog), .softstart_ref(ssref),
        .switching_active(active), .string_shorted(shorted), .string_marked_off(marked));
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic end_sim;
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic wait_active(input logic v);
        int i;
        for (i = 0; i < 80 && active !== v; i++) step(1);
        if (i == 80) begin
            failures++;
            end_sim();
        end
    endtask : wait_active
    task automatic measure(input int n);
        logic ps, pw;
        {c_sink, r_sink, c_sw, r_sw} = '0;
        ps = sink[0];
        pw = sw;
        repeat (n) begin
            step(1);
            c_sink += int'(sink[0]);
            r_sink += int'(sink[0] && !ps);
            c_sw += int'(sw);
            r_sw += int'(sw && !pw);
            ps = sink[0];
            pw = sw;
        end
    endtask : measure
    // string on-cycles over two output dim periods of 1509 clocks
    function automatic int exp_on(input int duty, input int a);
        return a ? 3018 : 2 * (duty * 4 * 1509 / 1024);
    endfunction : exp_on
    initial begin
        void'($urandom(32'h0052));
        step(12);
        reset = 1'b0;
        step(2);
        check(amp, 20'h100);
        en_req = 1'b1;
        step(7000);
        check(active, 20'h0);
        above_short = 1'b1;
        wait_active(1'b1);
        for (int k = 0; k < 5; k++) begin
            period = (k < 3) ? pt[k] : 2000 + $urandom_range(500);
            high = (k < 3) ? ht[k] : period / 8 + $urandom_range(period * 3 / 4);
            step(3 * period + 40);
            d = high * 1024 / period;
            exp_a = (d >= 256) ? 1 : (d < 254) ? 0 : exp_a;
            check(analog, 20'(exp_a));
            check(amp, exp_a ? 20'(d) : 20'h100);
            measure(3018);
            check(c_sink, 20'(exp_on(d, exp_a)));
            check(r_sink, exp_a ? 20'h0 : 20'h2);
        end
        check(ssref, 20'hff);
        peak = 1'b0;
        step(200);
        peak = 1'b1;
        step(20);
        measure(670);
        check(r_sw, 20'ha);
        check(c_sw, 20'h28);
        light = 1'b1;
        step(200);
        measure(670);
        check(r_sw, 20'h0);
        light = 1'b0;
        {s_low, ovs, recov} = {6'h04, 1'b1, 1'b0};
        step(12);
        check(active, 20'h0);
        check(marked, 20'h4);
        check(fb, 20'h3b);
        {ovs, recov} = 2'b01;
        wait_active(1'b1);
        s_low = 6'h0;
        step(8);
        check(marked, 20'h0);
        s_high = 6'h20;
        step(449);
        check(shorted, 20'h0);
        step(154);
        check(shorted, 20'h20);
        check(sink[5], 20'h0);
        s_high = 6'h0;
        step(8);
        check(fb, 20'h3f);
        over_temp = 1'b1;
        step(10);
        check(active, 20'h0);
        over_temp = 1'b0;
        wait_active(1'b1);
        supply_ok = 1'b0;
        step(10);
        check(sink, 20'h0);
        supply_ok = 1'b1;
        wait_active(1'b1);
        en_req = 1'b0;
        step(10);
        check(active, 20'h0);
        end_sim();
    end
endmodule : test_led_backlight_dim_protect_ctrl
